/* File: hw/tx_descriptor_status_control.sv */
// Transmit descriptor status write-back and control word interpretation
//
// Functional notes
// R1: Set excess-collision bit 8 when frame abandoned after 16 collisions.
// R2: Report collision count before send in bits 6:3.
// R3: With deferral check on, set bit 2 after deferral over 24288 bits.
// R4: Set bit 1 when host data arrives too late (underrun abort).
// R5: Set bit 0 when sending was postponed due to carrier present.
// R6: Reserved status bit 7 is written as zero.
// R7: Last segment with irq bit set raises tx interrupt after sending.
// R8: Control bit 30 marks the frame's final segment.
// R9: Control bit 29 marks the frame's opening segment.
// R10: Control bit 28 ignored; control word never written by device.
// R11: Checksum bit, first segment and global enable request L3 checksum.
// R12: Host reads collision count and errors from written-back status.
// R13: Bit 15 is OR of underrun, deferral, collision and carrier errors.
// R14: Set bit 9 on collision beyond the 64-byte window.
// R15: Status written back only after frame finished or abandoned.
`timescale 1ns/1ps
module tx_descriptor_status_control #(
    parameter int DEFER_LIMIT = txdesc_pkg::DEFER_LIMIT_BITS,
    parameter int COLL_LIMIT = txdesc_pkg::MAX_COLLISIONS
) (
    input wire logic core_clk,
    input wire logic rstn,
    // Descriptor fetched from host memory
    input wire logic desc_valid,
    input wire logic [31:0] tx_desc_control_word,
    // Global configuration
    input wire logic deferral_check_enable,
    input wire logic checksum_offload_enable,
    // Transmit MAC events for the frame in flight
    input wire txdesc_pkg::tx_events_s mac_events,
    input wire logic mac_done,
    // Status write-back
    output logic status_wb_valid,
    output logic [31:0] tx_desc_status_word,
    output logic tx_interrupt_flag,
    input wire logic tx_interrupt_clear,
    // Frame framing and checksum request toward the MAC side
    output logic frame_start,
    output logic frame_end_pending,
    output logic tx_checksum_engine,
    output logic mac_abort
);
    // Refuse limits that the 4-bit tally or the counter cannot serve
    if (COLL_LIMIT < 2 || COLL_LIMIT > 16) begin
        $error("COLL_LIMIT out of range");
    end
    if (DEFER_LIMIT < 1) begin
        $error("DEFER_LIMIT must be positive");
    end

    // ****************************************
    // Control word decode
    // ****************************************
    txdesc_pkg::ctrl_bits_s ctrl;
    // Reserved bit 28 is never looked at
    assign ctrl.irq_on_completion = tx_desc_control_word[txdesc_pkg::CT_IRQ];
    assign ctrl.last_segment_mark = tx_desc_control_word[txdesc_pkg::CT_LAST];
    assign ctrl.first_segment_mark =
        tx_desc_control_word[txdesc_pkg::CT_FIRST];
    assign ctrl.tx_checksum_request =
        tx_desc_control_word[txdesc_pkg::CT_CHECKSUM];

    logic in_frame;
    logic irq_armed;

    // Frame bounds from first/last marks  R8 R9 R10
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            in_frame <= 1'b0;
            irq_armed <= 1'b0;
            frame_start <= 1'b0;
            frame_end_pending <= 1'b0;
            tx_checksum_engine <= 1'b0;
        end else begin
            frame_start <= desc_valid && ctrl.first_segment_mark; // R9
            // Close first, so a descriptor in the same cycle opens anew
            if (mac_done) begin
                in_frame <= 1'b0;
                frame_end_pending <= 1'b0;
                irq_armed <= 1'b0;
                tx_checksum_engine <= 1'b0;
            end
            if (desc_valid && ctrl.first_segment_mark) begin
                in_frame <= 1'b1; // R9
                tx_checksum_engine <= ctrl.tx_checksum_request &&
                    checksum_offload_enable; // R11
            end
            if (desc_valid && ctrl.last_segment_mark) begin
                frame_end_pending <= 1'b1; // R8
                irq_armed <= ctrl.irq_on_completion; // R7
            end
        end
    end

    // ****************************************
    // Event accumulation for the current frame
    // ****************************************
    logic [4:0] coll_count;
    // Sized from the parameter so that a longer limit still fits
    logic [$clog2(DEFER_LIMIT + 1) - 1:0] defer_count;
    logic deferred;
    logic underrun;
    logic late_coll;
    logic no_carrier;
    logic loss_carrier;
    logic exc_coll;
    logic exc_defer;
    localparam logic [4:0] COLL_MAX = 5'(COLL_LIMIT);

    always_ff @(posedge core_clk) begin
        if (!rstn || status_wb_valid) begin
            coll_count <= 5'h00;
            exc_coll <= 1'b0;
        end else if (mac_events.collision && !exc_coll) begin
            coll_count <= coll_count + 5'h01; // R2
            if (coll_count + 5'h01 >= COLL_MAX)
                exc_coll <= 1'b1; // R1
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn || status_wb_valid) begin
            defer_count <= '0;
            exc_defer <= 1'b0;
        end else if (mac_events.defer_bit_time) begin
            if (defer_count < $bits(defer_count)'(DEFER_LIMIT))
                defer_count <= defer_count + 1'b1;
            else if (deferral_check_enable)
                exc_defer <= 1'b1; // R3
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn || status_wb_valid) begin
            deferred <= 1'b0;
            underrun <= 1'b0;
            late_coll <= 1'b0;
            no_carrier <= 1'b0;
            loss_carrier <= 1'b0;
        end else begin
            if (mac_events.deferred)
                deferred <= 1'b1; // R5
            if (mac_events.underrun)
                underrun <= 1'b1; // R4
            if (mac_events.late_collision)
                late_coll <= 1'b1; // R14
            if (mac_events.no_carrier)
                no_carrier <= 1'b1;
            if (mac_events.loss_carrier)
                loss_carrier <= 1'b1;
        end
    end

    // Abandon request to the MAC on fatal conditions
    assign mac_abort = exc_coll || exc_defer || underrun || late_coll;

    // ****************************************
    // Status word assembly and write-back
    // ****************************************
    logic [31:0] next_status;
    logic err_sum;
    assign err_sum = underrun || exc_defer || exc_coll || late_coll ||
        no_carrier || loss_carrier; // R13

    always_comb begin
        next_status = txdesc_pkg::STATUS_RESET;
        next_status[txdesc_pkg::ST_DEFERRED] = deferred; // R5
        next_status[txdesc_pkg::ST_UNDERRUN] = underrun; // R4
        next_status[txdesc_pkg::ST_EXC_DEFER] = exc_defer; // R3
        next_status[txdesc_pkg::ST_TALLY_HI:txdesc_pkg::ST_TALLY_LO] =
            coll_count[3:0]; // R2
        next_status[txdesc_pkg::ST_RSVD7] = 1'b0; // R6
        next_status[txdesc_pkg::ST_EXC_COLL] = exc_coll; // R1
        next_status[txdesc_pkg::ST_LATE_COLL] = late_coll; // R14
        next_status[txdesc_pkg::ST_NO_CARRIER] = no_carrier;
        next_status[txdesc_pkg::ST_LOSS_CARRIER] = loss_carrier;
        next_status[txdesc_pkg::ST_ERR_SUMMARY] = err_sum; // R13
    end

    // Written only once the MAC reports the frame over; the host then
    // reads counts and errors from this word  R15 R12
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            status_wb_valid <= 1'b0;
            tx_desc_status_word <= txdesc_pkg::STATUS_RESET;
        end else begin
            status_wb_valid <= mac_done; // R15
            if (mac_done)
                tx_desc_status_word <= next_status; // R15
        end
    end

    // Interrupt flag: set wins over clear  R7
    always_ff @(posedge core_clk) begin
        if (!rstn)
            tx_interrupt_flag <= 1'b0;
        else if (mac_done && irq_armed)
            tx_interrupt_flag <= 1'b1; // R7
        else if (tx_interrupt_clear)
            tx_interrupt_flag <= 1'b0;
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_wb_after_done;
        @(posedge core_clk) disable iff (!rstn)
        mac_done |=> status_wb_valid;
    endproperty
    a_wb_after_done: assert property (p_wb_after_done) // R15
        else $error("status not written after frame end");

    property p_wb_only_after_done;
        @(posedge core_clk) disable iff (!rstn)
        status_wb_valid |-> $past(mac_done);
    endproperty
    a_wb_only_after_done: assert property (p_wb_only_after_done) // R15
        else $error("status written without frame end");

    property p_rsvd7_zero;
        @(posedge core_clk) disable iff (!rstn)
        status_wb_valid |-> !tx_desc_status_word[txdesc_pkg::ST_RSVD7];
    endproperty
    a_rsvd7_zero: assert property (p_rsvd7_zero) // R6
        else $error("reserved status bit set");

    property p_err_summary;
        @(posedge core_clk) disable iff (!rstn)
        status_wb_valid |-> tx_desc_status_word[15] ==
            (|{tx_desc_status_word[11:8], tx_desc_status_word[2:1]});
    endproperty
    a_err_summary: assert property (p_err_summary) // R13
        else $error("error summary mismatch");

    property p_irq_set;
        @(posedge core_clk) disable iff (!rstn)
        mac_done && irq_armed |=> tx_interrupt_flag;
    endproperty
    a_irq_set: assert property (p_irq_set) // R7
        else $error("interrupt not raised on completion");

    property p_irq_cause;
        @(posedge core_clk) disable iff (!rstn)
        $rose(tx_interrupt_flag) |-> $past(mac_done && irq_armed);
    endproperty
    a_irq_cause: assert property (p_irq_cause) // R7
        else $error("interrupt without armed completion");

    property p_exc_coll;
        @(posedge core_clk) disable iff (!rstn)
        $rose(exc_coll) |-> $past(coll_count) == COLL_MAX - 5'h01;
    endproperty
    a_exc_coll: assert property (p_exc_coll) // R1
        else $error("excess collision at wrong count");

    property p_exc_defer_en;
        @(posedge core_clk) disable iff (!rstn)
        $rose(exc_defer) |-> $past(deferral_check_enable);
    endproperty
    a_exc_defer_en: assert property (p_exc_defer_en) // R3
        else $error("excess deferral while check disabled");

    property p_underrun_wb;
        @(posedge core_clk) disable iff (!rstn)
        mac_events.underrun && !status_wb_valid && !mac_done ##1 mac_done
        |=> tx_desc_status_word[txdesc_pkg::ST_UNDERRUN];
    endproperty
    a_underrun_wb: assert property (p_underrun_wb) // R4
        else $error("underrun not reported");

    property p_cksum;
        @(posedge core_clk) disable iff (!rstn)
        desc_valid && ctrl.first_segment_mark && !mac_done |=>
            tx_checksum_engine == $past(ctrl.tx_checksum_request &&
            checksum_offload_enable);
    endproperty
    a_cksum: assert property (p_cksum) // R11
        else $error("checksum request decode wrong");

    property p_frame_open;
        @(posedge core_clk) disable iff (!rstn)
        frame_start |-> in_frame;
    endproperty
    a_frame_open: assert property (p_frame_open) // R9
        else $error("frame start without open frame");

    property p_word_held;
        @(posedge core_clk) disable iff (!rstn)
        status_wb_valid && !mac_done |=> $stable(tx_desc_status_word);
    endproperty
    a_word_held: assert property (p_word_held) // R12
        else $error("status word changed while host reads it");

    c_irq: cover property (@(posedge core_clk) disable iff (!rstn)
        $rose(tx_interrupt_flag));
    c_exc_coll: cover property (@(posedge core_clk) disable iff (!rstn)
        status_wb_valid && tx_desc_status_word[txdesc_pkg::ST_EXC_COLL]);
    c_clean: cover property (@(posedge core_clk) disable iff (!rstn)
        status_wb_valid && !tx_desc_status_word[15]);
    c_exc_defer: cover property (@(posedge core_clk) disable iff (!rstn)
        status_wb_valid && tx_desc_status_word[txdesc_pkg::ST_EXC_DEFER]);
endmodule

/* File: pkg/txdesc_pkg.sv */
// Package: descriptor field layout, limits and MAC event and control types for tx status
package txdesc_pkg;
    // Status word bit positions
    localparam int ST_DEFERRED = 0;
    localparam int ST_UNDERRUN = 1;
    localparam int ST_EXC_DEFER = 2;
    localparam int ST_TALLY_LO = 3;
    localparam int ST_TALLY_HI = 6;
    localparam int ST_RSVD7 = 7;
    localparam int ST_EXC_COLL = 8;
    localparam int ST_LATE_COLL = 9;
    localparam int ST_NO_CARRIER = 10;
    localparam int ST_LOSS_CARRIER = 11;
    localparam int ST_ERR_SUMMARY = 15;
    // Control word bit positions
    localparam int CT_CHECKSUM = 27;
    localparam int CT_RSVD28 = 28;
    localparam int CT_FIRST = 29;
    localparam int CT_LAST = 30;
    localparam int CT_IRQ = 31;
    // Limits
    localparam int MAX_COLLISIONS = 16;
    localparam int DEFER_LIMIT_BITS = 24288;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

    typedef struct packed {
        logic deferred;
        logic underrun;
        logic late_collision;
        logic no_carrier;
        logic loss_carrier;
        logic collision;
        logic defer_bit_time;
    } tx_events_s;

    typedef struct packed {
        logic irq_on_completion;
        logic last_segment_mark;
        logic first_segment_mark;
        logic tx_checksum_request;
    } ctrl_bits_s;
endpackage

/* File: verification/host_driver_model.sv */
// Host driver model: posts descriptor control words, reads back status
`timescale 1ns/1ps
module host_driver_model (
    input wire logic core_clk,
    input wire logic issue,
    input wire txdesc_pkg::ctrl_bits_s bits,
    input wire logic [31:0] noise,
    input wire logic status_wb_valid,
    input wire logic [31:0] tx_desc_status_word,
    output logic desc_valid,
    output logic [31:0] tx_desc_control_word,
    output logic [3:0] read_tally,
    output logic read_error
);
    initial begin
        desc_valid = 1'b0;
        tx_desc_control_word = 32'h0000_0000;
        read_tally = 4'h0;
        read_error = 1'b0;
    end
    always @(posedge core_clk) begin
        desc_valid <= issue;
        if (issue) begin
            tx_desc_control_word <= {bits.irq_on_completion,
                bits.last_segment_mark, bits.first_segment_mark, 1'b0,
                bits.tx_checksum_request, noise[26:0]};
        end else begin
            // Stale outside the strobe, so never leave the last value up
            tx_desc_control_word <= ~tx_desc_control_word;
        end
    end
    // Reserved bit 7 is never looked at
    always @(posedge core_clk) begin
        if (status_wb_valid) begin
            read_tally <= tx_desc_status_word[6:3];
            read_error <= tx_desc_status_word[15];
        end
    end
endmodule

/* File: verification/tx_descriptor_status_control_bench.sv */
// Testbench for tx descriptor status write-back and control decoding
`timescale 1ns/1ps
module tx_descriptor_status_control_bench;
    localparam int DL = 20;
    logic core_clk, rstn, issue, desc_valid, deferral_check_enable;
    logic checksum_offload_enable, mac_done, tx_interrupt_clear;
    logic status_wb_valid, tx_interrupt_flag, frame_start, read_error;
    logic frame_end_pending, tx_checksum_engine, mac_abort;
    logic [31:0] tx_desc_control_word, tx_desc_status_word, noise, exp_w;
    logic [3:0] read_tally;
    logic df, un, lt, nc, lc, exc, ed;
    txdesc_pkg::tx_events_s mac_events, ev;
    txdesc_pkg::ctrl_bits_s bits;
    int fail_count, comparisons, n, d, cyc;

    tx_descriptor_status_control #(.DEFER_LIMIT(DL), .COLL_LIMIT(16))
    i_tx_descriptor_status_control (
        .core_clk(core_clk), .rstn(rstn), .desc_valid(desc_valid),
        .tx_desc_control_word(tx_desc_control_word),
        .deferral_check_enable(deferral_check_enable),
        .checksum_offload_enable(checksum_offload_enable),
        .mac_events(mac_events), .mac_done(mac_done),
        .status_wb_valid(status_wb_valid),
        .tx_desc_status_word(tx_desc_status_word),
        .tx_interrupt_flag(tx_interrupt_flag),
        .tx_interrupt_clear(tx_interrupt_clear),
        .frame_start(frame_start), .frame_end_pending(frame_end_pending),
        .tx_checksum_engine(tx_checksum_engine), .mac_abort(mac_abort));

    host_driver_model i_host_driver_model (
        .core_clk(core_clk), .issue(issue), .bits(bits), .noise(noise),
        .status_wb_valid(status_wb_valid),
        .tx_desc_status_word(tx_desc_status_word),
        .desc_valid(desc_valid),
        .tx_desc_control_word(tx_desc_control_word),
        .read_tally(read_tally), .read_error(read_error));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic conclude;
        if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    // Far longer than the frames below can take
    initial begin
        #100000;
        fail_count++;
        conclude();
    end

    // ************************************************
    // Frames with random control bits and MAC events
    // ************************************************
    initial begin
        rstn = 1'b0;
        issue = 1'b0;
        bits = '0;
        noise = 32'h0000_0000;
        deferral_check_enable = 1'b0;
        checksum_offload_enable = 1'b0;
        mac_events = '0;
        mac_done = 1'b0;
        tx_interrupt_clear = 1'b0;
        fail_count = 0;
        comparisons = 0;
        void'($urandom(4965));
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        #1 chk({status_wb_valid, tx_interrupt_flag, frame_start,
                frame_end_pending, tx_checksum_engine}, 0, "reset");
        for (int i = 0; i < 24; i++) begin
            n = $urandom_range(18, 0);
            d = $urandom_range(23, 0);
            {df, un, lt, nc, lc} = 5'($urandom) & 5'($urandom);
            // Boundaries of the collision and deferral limits first
            if (i < 4) begin
                n = 16 - i % 2;
                d = DL + 1 - i / 2;
                {df, un, lt, nc, lc} = 5'h00;
            end
            bits = 4'($urandom);
            noise = $urandom;
            @(posedge core_clk);
            issue <= 1'b1;
            tx_interrupt_clear <= 1'b1;
            deferral_check_enable <= 1'($urandom);
            checksum_offload_enable <= 1'($urandom);
            @(posedge core_clk);
            issue <= 1'b0;
            tx_interrupt_clear <= 1'b0;
            @(posedge core_clk);
            #1 chk(frame_start, bits.first_segment_mark, "start");
            chk(frame_end_pending, bits.last_segment_mark, "end");
            chk(tx_checksum_engine, bits.tx_checksum_request &
                bits.first_segment_mark & checksum_offload_enable,
                "checksum");
            chk(tx_interrupt_flag, 0, "irq clear");
            cyc = (n > d) ? n : d;
            if (cyc == 0) cyc = 1;
            for (int c = 0; c < cyc; c++) begin
                @(posedge core_clk);
                ev = '0;
                ev.collision = (c < n);
                ev.defer_bit_time = (c < d);
                if (c == cyc - 1) begin
                    {ev.deferred, ev.underrun, ev.late_collision,
                     ev.no_carrier, ev.loss_carrier} = {df, un, lt, nc, lc};
                end
                mac_events <= ev;
                #1 chk(status_wb_valid, 0, "early write-back");
            end
            @(posedge core_clk);
            mac_events <= '0;
            mac_done <= 1'b1;
            exc = (n >= 16);
            ed = deferral_check_enable && (d > DL);
            #1 chk(mac_abort, un | exc | lt | ed, "abort");
            @(posedge core_clk);
            mac_done <= 1'b0;
            exp_w = 32'h0000_0000;
            exp_w[0] = df;
            exp_w[1] = un;
            exp_w[2] = ed;
            exp_w[6:3] = exc ? 4'h0 : 4'(n);
            exp_w[8] = exc;
            exp_w[9] = lt;
            exp_w[10] = nc;
            exp_w[11] = lc;
            exp_w[15] = un | ed | exc | lt | nc | lc;
            #1 chk(status_wb_valid, 1, "write-back");
            chk(tx_desc_status_word, exp_w, "status");
            chk(tx_desc_status_word[15], exp_w[15], "summary");
            chk(tx_interrupt_flag, bits.irq_on_completion &
                bits.last_segment_mark, "irq");
            @(posedge core_clk);
            #1 chk(read_tally, exp_w[6:3], "host tally");
            chk(read_error, exp_w[15], "host error");
            chk(status_wb_valid, 0, "strobe width");
        end
        conclude();
    end
endmodule
